/* core/bscan_observe.v */
// boundary-scan data register and signal-observe data register
// assumes an external tap supplies controller state and instruction; all test
// inputs arrive from another domain and are sampled by core_clk
`timescale 1ns/1ps
`include "bscan_observe_defs.vh"

// Function
// - extest reset state: cells pass through
// - extest capture loads parallel inputs
// - shift toward output; hold in exit/pause
// - update latches shift stage; else hold
// - extest output shows latch, falling edge update
// - sample capture loads parallel inputs
// - sample keeps cells transparent always
// - two-bit stage chained to address registers
// - update ends shifting; registers then hold
// - capture after update loads observed results
// - capture only with valid address; address holds
// - stage and address shift together outward
// - results driven on reserved observe pins
// - legacy clock and data ignored under observe
// - legacy pins work under other instructions
// - three cells per system pin
// - code 000 selects extest
// - code 001 selects sample/preload
// - code 011 selects observe register
module bscan_observe (
   input wire core_clk,
   input wire rst_n,
   input wire test_clk_pin,
   input wire test_data_in_pin,
   input wire [3:0] tap_state_pin,
   input wire [2:0] instr_code_pin,
   output reg test_data_out,
   output reg test_data_out_oe,
   input wire [1:0] pad_in_data,
   input wire [1:0] core_out_data,
   input wire [1:0] core_out_en,
   output wire [1:0] core_in_data,
   output wire [1:0] pad_out_data,
   output wire [1:0] pad_out_en,
   input wire [15:0] internal_nodes,
   input wire legacy_observe_clock_pin,
   input wire legacy_observe_data_pin,
   input wire probe_pins_reserved,
   output reg observe_output_a,
   output reg observe_output_b,
   output reg observe_output_oe,
   output wire [1:0] result_data,
   output wire result_valid,
   input wire result_ready,
   output reg result_dropped
);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [11:0] sync1_q;
   reg [11:0] sync2_q;
   reg [1:0] pad_s1_q;
   reg [1:0] pad_s2_q;
   reg tck_d_q;
   reg lck_d_q;
   wire tck;
   wire tdi;
   wire [3:0] state;
   wire [2:0] instr;
   wire lck;
   wire ldat;
   wire reserved;

   // first stage is read only by the second; all test pins come from outside
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // state field resets to test-logic-reset so the pads stay transparent
         sync1_q <= `SYNC_RST;
         sync2_q <= `SYNC_RST;
         pad_s1_q <= 2'h0;
         pad_s2_q <= 2'h0;
         tck_d_q <= 1'b0;
         lck_d_q <= 1'b0;
      end else begin
         sync1_q <= {probe_pins_reserved, legacy_observe_data_pin,
            legacy_observe_clock_pin, instr_code_pin, tap_state_pin,
            test_data_in_pin, test_clk_pin};
         sync2_q <= sync1_q;
         pad_s1_q <= pad_in_data;
         pad_s2_q <= pad_s1_q;
         tck_d_q <= tck;
         lck_d_q <= lck;
      end
   end

   assign tck = sync2_q[0];
   assign tdi = sync2_q[1];
   assign state = sync2_q[5:2];
   assign instr = sync2_q[8:6];
   assign lck = sync2_q[9];
   assign ldat = sync2_q[10];
   assign reserved = sync2_q[11];

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire tck_rise = tck & ~tck_d_q;
   wire tck_fall = ~tck & tck_d_q;
   wire lck_rise = lck & ~lck_d_q;
   wire is_extest = (instr == `INSTR_EXTEST);
   wire is_sample = (instr == `INSTR_SAMPLE_PRELOAD);
   wire is_observe = (instr == `INSTR_SIGNAL_OBSERVE);
   wire bs_selected = is_extest | is_sample;
   wire in_capture = (state == `ST_CAPTURE_DR);
   wire in_shift = (state == `ST_SHIFT_DR);
   wire in_update = (state == `ST_UPDATE_DR);
   wire in_reset = (state == `ST_TEST_LOGIC_RESET);
   // exits and pause: every data stage keeps its contents
   wire in_hold = (state == `ST_EXIT1_DR) | (state == `ST_PAUSE_DR) |
      (state == `ST_EXIT2_DR);

   // a select is valid only below the number of observed nodes
   function sel_ok;
      input [3:0] sel;
      begin
         sel_ok = (sel < `NODE_COUNT);
      end
   endfunction

   // picks one observed node; out of range selects give zero
   function node_pick;
      input [15:0] nodes;
      input [3:0] sel;
      begin
         node_pick = sel_ok(sel) ? nodes[sel] : 1'b0;
      end
   endfunction

   // ----------------------------------------
   // boundary cells: parallel inputs, three per pin
   // ----------------------------------------
   wire [5:0] cell_parallel_in;
   wire [5:0] cell_parallel_out;
   reg [5:0] bs_shift_q;
   reg [5:0] cell_latched_output;
   // transparent unless extest owns the pins outside the reset state
   wire bs_drive_latched = is_extest & ~in_reset;

   genvar p;
   generate
      for (p = 0; p < `NUM_PINS; p = p + 1) begin : g_pin
         // oe cell, output cell, input cell per pin, oe cell nearest the output
         assign cell_parallel_in[p*`CELLS_PER_PIN + `OE_CELL] = core_out_en[p];
         assign cell_parallel_in[p*`CELLS_PER_PIN + `OUT_CELL] = core_out_data[p];
         assign cell_parallel_in[p*`CELLS_PER_PIN + `IN_CELL] = pad_s2_q[p];
         assign pad_out_en[p] = cell_parallel_out[p*`CELLS_PER_PIN + `OE_CELL];
         assign pad_out_data[p] = cell_parallel_out[p*`CELLS_PER_PIN + `OUT_CELL];
         assign core_in_data[p] = cell_parallel_out[p*`CELLS_PER_PIN + `IN_CELL];
      end
   endgenerate

   // output follows the latch under extest outside reset, else the input straight through
   assign cell_parallel_out = bs_drive_latched ? cell_latched_output
      : cell_parallel_in;

   // one-cycle strokes of the boundary register, taken from the detected edges
   wire bs_cap_en = tck_rise & bs_selected & in_capture;
   wire bs_shift_en = tck_rise & bs_selected & in_shift;
   wire bs_hold_en = tck_rise & bs_selected & in_hold;
   wire bs_upd_en = tck_fall & bs_selected & in_update;

   // shift and latch stages of the boundary register
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bs_shift_q <= `CELLS_RST;
         cell_latched_output <= `CELLS_RST;
      end else begin
         if (bs_cap_en) begin
            bs_shift_q <= cell_parallel_in;
         end else if (bs_shift_en) begin
            bs_shift_q <= {tdi, bs_shift_q[5:1]};
         end else if (bs_hold_en) begin
            bs_shift_q <= bs_shift_q;
         end
         // new latch value appears on the falling test clock edge
         if (bs_upd_en) begin
            cell_latched_output <= bs_shift_q;
         end
      end
   end

   // ----------------------------------------
   // signal-observe register
   // ----------------------------------------
   reg [1:0] observe_shift_stage;
   reg [7:0] obs_addr_q;
   reg push_q;
   wire addr_valid;
   wire [1:0] obs_result;

   // low nibble picks output a, high nibble picks output b
   assign addr_valid = sel_ok(obs_addr_q[3:0]) &
      sel_ok(obs_addr_q[7:4]);
   assign obs_result = {node_pick(internal_nodes, obs_addr_q[7:4]),
      node_pick(internal_nodes, obs_addr_q[3:0])};

   // strokes of the observe chain; a bad address makes capture a no-op
   wire obs_cap_en = tck_rise & in_capture & addr_valid;
   wire obs_shift_en = tck_rise & in_shift;
   wire obs_hold_en = tck_rise & (in_hold | in_update);

   // address and stage form one chain: tdi into the address, stage bit 0 out
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         observe_shift_stage <= `STAGE_RST;
         obs_addr_q <= `ADDR_RST;
         push_q <= 1'b0;
      end else begin
         push_q <= 1'b0;
         if (is_observe) begin
            // legacy clock and data have no effect here
            if (obs_cap_en) begin
               observe_shift_stage <= obs_result;
               push_q <= 1'b1;
            end else if (obs_shift_en) begin
               observe_shift_stage <= {obs_addr_q[0], observe_shift_stage[1]};
               obs_addr_q <= {tdi, obs_addr_q[7:1]};
            end else if (obs_hold_en) begin
               // update ends shifting; exits and pause keep both parts
               observe_shift_stage <= observe_shift_stage;
               obs_addr_q <= obs_addr_q;
            end
         end else if (lck_rise) begin
            obs_addr_q <= {ldat, obs_addr_q[7:1]};
         end
      end
   end

   // observe pins carry the selected nodes when reserved for it
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         observe_output_a <= 1'b0;
         observe_output_b <= 1'b0;
         observe_output_oe <= 1'b0;
      end else begin
         observe_output_a <= reserved & obs_result[0];
         observe_output_b <= reserved & obs_result[1];
         observe_output_oe <= reserved;
      end
   end

   // ----------------------------------------
   // result stream; capture cannot wait for the tester, so a full buffer drops
   // ----------------------------------------
   wire fifo_in_ready;

   obs_fifo #(
      .WIDTH(`OBS_STAGE_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_data(observe_shift_stage),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .out_data(result_data),
      .out_valid(result_valid),
      .out_ready(result_ready)
   );

   // one-cycle flag when a result finds the buffer full
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_dropped <= 1'b0;
      end else begin
         result_dropped <= push_q & ~fifo_in_ready;
      end
   end

   // ----------------------------------------
   // serial output, changed on the falling test clock edge
   // ----------------------------------------
   wire shift_out_bit = is_observe ? observe_shift_stage[0] : bs_shift_q[0];
   wire drive_en = in_shift & (bs_selected | is_observe);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_data_out <= 1'b0;
         test_data_out_oe <= 1'b0;
      end else if (tck_fall) begin
         // driven only while one of our registers is in the path and shifting
         test_data_out <= shift_out_bit;
         test_data_out_oe <= drive_en;
      end
   end

   // ----------------------------------------
   // hold states
   // ----------------------------------------
   // exit1, exit2 and pause only refresh the stages with their own value; the
   // tester leaves shift only through exit1, which ends shifting

endmodule // bscan_observe

/* core/bscan_observe_defs.vh */
// constants for the boundary-scan and signal-observe data registers
// assumes the controller state and current instruction come from an external tap
`ifndef BSCAN_OBSERVE_DEFS_VH
`define BSCAN_OBSERVE_DEFS_VH

// ----------------------------------------
// controller states (4-bit codes)
// ----------------------------------------
`define ST_TEST_LOGIC_RESET 4'hf
`define ST_CAPTURE_DR 4'h6
`define ST_SHIFT_DR 4'h2
`define ST_EXIT1_DR 4'h1
`define ST_PAUSE_DR 4'h3
`define ST_EXIT2_DR 4'h0
`define ST_UPDATE_DR 4'h5

// ----------------------------------------
// instruction codes (3-bit)
// ----------------------------------------
`define INSTR_EXTEST 3'h0
`define INSTR_SAMPLE_PRELOAD 3'h1
`define INSTR_SIGNAL_OBSERVE 3'h3

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define NUM_PINS 2
`define CELLS_PER_PIN 3
`define NUM_CELLS 6
`define OE_CELL 0
`define OUT_CELL 1
`define IN_CELL 2
`define OBS_STAGE_W 2
`define OBS_ADDR_W 8
`define OBS_SEL_W 4
`define NODE_BUS_W 16
`define NODE_COUNT 4'hc
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CELLS_RST 6'h00
`define STAGE_RST 2'h0
`define ADDR_RST 8'h00
`define SYNC_RST 12'h03c

`endif

/* core/obs_fifo.v */
// small first-in first-out buffer with registered read data
// assumes a single clock; push and pop are valid/ready handshakes
`timescale 1ns/1ps

module obs_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire core_clk,
   input wire rst_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output reg out_valid,
   input wire out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] count_q;
   wire push;
   wire pop_mem;

   // ----------------------------------------
   // handshake terms
   // ----------------------------------------
   assign in_ready = (count_q != DEPTH[AW:0]);
   assign push = in_valid & in_ready;
   // move a word into the output register whenever it is free or being taken
   assign pop_mem = (count_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

   // storage array, written only, no reset needed
   always @(posedge core_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers, occupancy and output register
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         out_data <= {WIDTH{1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop_mem) begin
            rd_q <= rd_q + 1'b1;
            out_data <= mem[rd_q];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
      end
   end

endmodule // obs_fifo

/* testbench/bscan_observe_properties.sv */
// checker for bscan_observe: mode transparency, hold and result stream timing
// assumes every test pin passes two synchroniser stages inside the block
`timescale 1ns/1ps
module bscan_observe_properties (
   input wire core_clk,
   input wire rst_n,
   input wire test_clk_pin,
   input wire [3:0] tap_state_pin,
   input wire [2:0] instr_code_pin,
   input wire test_data_out,
   input wire [1:0] core_out_data,
   input wire [1:0] core_out_en,
   input wire [1:0] pad_out_data,
   input wire [1:0] pad_out_en,
   input wire probe_pins_reserved,
   input wire observe_output_a,
   input wire observe_output_b,
   input wire observe_output_oe,
   input wire [1:0] result_data,
   input wire result_valid,
   input wire result_ready,
   input wire result_dropped
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // a setting is judged only once it has outlived the synchronisers
   AST_TLR_PASS: assert property (
      (instr_code_pin == 3'h0 && tap_state_pin == 4'hf)[*5]
      |-> pad_out_data == core_out_data && pad_out_en == core_out_en) else $error("tlr pass");
   AST_SAMPLE_PASS: assert property (
      (instr_code_pin == 3'h1)[*5]
      |-> pad_out_data == core_out_data && pad_out_en == core_out_en) else $error("sample pass");
   AST_SHIFT_HOLD: assert property (
      (instr_code_pin == 3'h0 && tap_state_pin == 4'h2)[*5]
      |-> $stable(pad_out_data) && $stable(pad_out_en)) else $error("latch moved");
   AST_OBS_ON: assert property (
      probe_pins_reserved[*5] |-> observe_output_oe) else $error("observe oe off");
   AST_OBS_OFF: assert property (
      (!probe_pins_reserved)[*5]
      |-> !observe_output_oe && !observe_output_a && !observe_output_b) else $error("observe on");
   // serial output may only move on a detected falling test clock
   AST_TDO_FALL: assert property (
      $changed(test_data_out) |-> !$past(test_clk_pin) && !$past(test_clk_pin, 2))
      else $error("tdo off fall");
   AST_STREAM_HOLD: assert property (
      result_valid && !result_ready |=> result_valid && $stable(result_data))
      else $error("result dropped early");
   AST_DROP_PULSE: assert property (
      result_dropped |=> !result_dropped) else $error("drop not a pulse");
endmodule // bscan_observe_properties

bind bscan_observe bscan_observe_properties chk_u (.core_clk, .rst_n, .test_clk_pin,
   .tap_state_pin, .instr_code_pin, .test_data_out, .core_out_data, .core_out_en, .pad_out_data,
   .pad_out_en, .probe_pins_reserved, .observe_output_a, .observe_output_b, .observe_output_oe,
   .result_data, .result_valid, .result_ready, .result_dropped);

/* testbench/tap_tester_model.sv */
// tester model: makes the test clock and steps the controller state code
// assumes the block samples these pins with its own faster clock
`timescale 1ns/1ps
module tap_tester_model (
   output logic test_clk_pin,
   output logic test_data_in_pin,
   output logic [3:0] tap_state_pin,
   output logic [2:0] instr_code_pin,
   input wire test_data_out
);
   initial begin
      test_clk_pin = 1'b0;
      test_data_in_pin = 1'b0;
      tap_state_pin = 4'hf; // power-up sits in test-logic-reset
      instr_code_pin = 3'h0;
   end
   // one test clock period; the clock stands low between frames
   task automatic tick(input logic [3:0] st, input logic di, output logic dout);
      tap_state_pin = st;
      test_data_in_pin = (st == 4'h2) ? di : ~test_data_in_pin; // unused data is not kept
      #40 dout = test_data_out;
      test_clk_pin = 1'b1;
      #40 test_clk_pin = 1'b0;
   endtask
   // capture, n shifts, exit1, pause, exit2, update, idle
   task automatic dr_scan(input logic [2:0] ins, input int n, input logic [9:0] din,
      output logic [9:0] dout);
      logic d;
      dout = 10'h000;
      instr_code_pin = ins;
      tick(4'h6, 1'b0, d);
      for (int i = 0; i < n; i++) tick(4'h2, din[i], dout[i]);
      tick(4'h1, 1'b0, d);
      tick(4'h3, 1'b0, d);
      tick(4'h0, 1'b0, d);
      tick(4'h5, 1'b0, d);
      tick(4'hc, 1'b0, d);
   endtask
endmodule // tap_tester_model

/* testbench/bscan_observe_tb.sv */
// self-checking bench for bscan_observe with the tester model on the test port
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module bscan_observe_tb;
   logic core_clk, rst_n, test_clk_pin, test_data_in_pin, test_data_out, test_data_out_oe;
   logic [3:0] tap_state_pin;
   logic [2:0] instr_code_pin;
   logic [1:0] pad_in_data, core_out_data, core_out_en, core_in_data, pad_out_data, pad_out_en;
   logic [1:0] result_data, exp_q[$];
   logic [15:0] internal_nodes;
   logic lclk, ldat, probe_pins_reserved, observe_output_a, observe_output_b, observe_output_oe;
   logic result_valid, result_ready, result_dropped;
   logic [5:0] d6;
   logic [7:0] addr, prev_addr;
   logic [9:0] dout, din, prev_din, exp;
   int errors = 0, checks_done = 0, seed = 50429, drops = 0, exp_drops = 0, oe_cycles = 0;

   bscan_observe dut_u (.core_clk, .rst_n, .test_clk_pin, .test_data_in_pin, .tap_state_pin,
      .instr_code_pin, .test_data_out, .test_data_out_oe, .pad_in_data, .core_out_data,
      .core_out_en, .core_in_data, .pad_out_data, .pad_out_en, .internal_nodes,
      .legacy_observe_clock_pin(lclk), .legacy_observe_data_pin(ldat), .probe_pins_reserved,
      .observe_output_a, .observe_output_b, .observe_output_oe, .result_data, .result_valid,
      .result_ready, .result_dropped);
   tap_tester_model tester_u (.test_clk_pin, .test_data_in_pin, .tap_state_pin,
      .instr_code_pin, .test_data_out);

   // -------------------------------------
   // expectations and shared tasks
   // -------------------------------------
   function automatic logic [5:0] cells(input logic [1:0] pi, co, ce);
      return {pi[1], co[1], ce[1], pi[0], co[0], ce[0]}; // bit0 leaves first
   endfunction
   // selects at or above the node count read as zero
   function automatic logic [1:0] probe(input logic [15:0] n, input logic [7:0] a);
      return {(a[7:4] < 4'hc) ? n[a[7:4]] : 1'b0, (a[3:0] < 4'hc) ? n[a[3:0]] : 1'b0};
   endfunction
   function automatic logic ok_addr(input logic [7:0] a);
      return a[3:0] < 4'hc && a[7:4] < 4'hc;
   endfunction
   task chk_vec(input logic [9:0] got, input logic [9:0] want, input string m);
      checks_done++;
      if (got !== want) begin
         errors++;
         $display("[ERR] %0t %s got %h want %h", $time, m, got, want);
      end
   endtask
   task chk_cnt(input int got, input int want, input string m);
      chk_vec(10'(got), 10'(want), m);
   endtask
   task scan(input logic [2:0] ins, input int n, input logic [9:0] d);
      @(negedge core_clk);
      tester_u.dr_scan(ins, n, d, dout);
   endtask
   // legacy serial address, first bit ends lowest
   task leg(input logic [7:0] a);
      @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
         ldat = a[i];
         #40 lclk = 1'b1;
         #40 lclk = 1'b0;
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // hang guard
   initial begin
      #600000;
      errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test;
   end
   // result stream watcher: a pop must match the oldest capture
   always @(posedge core_clk) begin
      if (result_dropped === 1'b1) drops++;
      if (test_data_out_oe === 1'b1) oe_cycles++;
      if (result_valid === 1'b1 && result_ready === 1'b1) begin
         if (exp_q.size() > 0)
            chk_vec(10'(result_data), 10'(exp_q.pop_front()), "stream word");
         else
            chk_cnt(1, 0, "extra word");
      end
   end

   initial begin
      rst_n = 1'b0;
      {pad_in_data, core_out_data, core_out_en, internal_nodes} = 22'h000000;
      {lclk, ldat, probe_pins_reserved, result_ready} = 4'h0;
      prev_addr = 8'h00;
      prev_din = 10'h000;
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      {pad_in_data, core_out_data, core_out_en} = 6'($random(seed));
      repeat (8) @(negedge core_clk);
      chk_vec(10'({pad_out_en, pad_out_data}), 10'({core_out_en, core_out_data}), "tlr");
      d6 = 6'($random(seed));
      scan(3'h1, 6, 10'(d6));
      chk_vec(dout, 10'(cells(pad_in_data, core_out_data, core_out_en)), "sample");
      chk_vec(10'({pad_out_en, pad_out_data}), 10'({core_out_en, core_out_data}), "pass");
      // six shift periods of 80 ns each, enable raised and dropped on detected falls
      chk_cnt(oe_cycles, 48, "oe span");
      // core side keeps moving; outputs must show only the latch
      for (int k = 0; k < 3; k++) begin
         d6 = 6'($random(seed));
         {pad_in_data, core_out_data, core_out_en} = 6'($random(seed));
         scan(3'h0, 6, 10'(d6));
         chk_vec(dout, 10'(cells(pad_in_data, core_out_data, core_out_en)), "ext cap");
         core_out_data = ~core_out_data;
         @(negedge core_clk);
         chk_vec(10'({core_in_data, pad_out_en, pad_out_data}),
            10'({d6[5], d6[2], d6[3], d6[0], d6[4], d6[1]}), "ext latch");
      end
      internal_nodes = 16'($random(seed));
      probe_pins_reserved = 1'b1;
      // fifo fills with the consumer stalled until captures are refused
      for (int k = 0; k < 24; k++) begin
         addr = {4'({$random(seed)} % 13), 4'({$random(seed)} % 13)};
         if (k == 3) addr = 8'hbb; // largest valid selects
         if (k == 5) addr = 8'h5c; // low select out of range
         din = {addr, 2'($random(seed))};
         scan(3'h3, 10, din);
         exp = ok_addr(prev_addr) ? {prev_addr, probe(internal_nodes, prev_addr)}
            : {prev_addr, prev_din[1:0]};
         chk_vec(dout, exp, "observe");
         if (ok_addr(prev_addr) && exp_q.size() == 17) exp_drops++;
         else if (ok_addr(prev_addr)) exp_q.push_back(probe(internal_nodes, prev_addr));
         prev_addr = addr;
         prev_din = din;
      end
      repeat (10) @(negedge core_clk);
      exp = 10'(probe(internal_nodes, prev_addr));
      chk_vec(10'({observe_output_b, observe_output_a}), exp, "pins");
      leg(~prev_addr);
      repeat (10) @(negedge core_clk);
      chk_vec(10'({observe_output_b, observe_output_a}), exp, "legacy off");
      for (int i = 0; i < 2000 && exp_q.size() > 0; i++) begin
         @(negedge core_clk);
         result_ready = 1'($random(seed));
      end
      chk_cnt(exp_q.size(), 0, "drain");
      repeat (4) @(negedge core_clk);
      chk_vec(10'(result_valid), 10'h000, "empty");
      chk_cnt(drops, exp_drops, "drops");
      scan(3'h7, 0, 10'h000); // foreign code hands the legacy pins back
      leg(8'h3a);
      repeat (10) @(negedge core_clk);
      exp = 10'(probe(internal_nodes, 8'h3a));
      chk_vec(10'({observe_output_b, observe_output_a}), exp, "legacy on");
      finish_test;
   end
endmodule // bscan_observe_tb
